// ### dv/fdm_host_bfm.sv
`timescale 1ns/1ps
`default_nettype none

module fdm_host_bfm (
  input wire logic sys_clk,
  output var fdm_pkg::fdm_strobe_s bus_strobe,
  output logic [12:0] addr,
  output logic [15:0] data_in,
  input wire logic [12:0] boot_addr,
  output logic [15:0] boot_rdata,
  input wire logic [15:0] data_out,
  input wire logic data_oe_n
);
  import fdm_pkg::*;

  localparam fdm_strobe_s IDLE = 4'hf;
  localparam fdm_strobe_s WR = 4'h3;
  localparam fdm_strobe_s RD = 4'h5;

  // array answers in the same clock; pattern ties data to its address
  assign boot_rdata = {3'h5, boot_addr};

  initial
  begin
    bus_strobe = IDLE;
    addr = 13'h0;
    data_in = 16'h0;
  end

  // write is ce plus we, held long enough for the pin synchronisers
  task automatic wr(input logic [12:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    addr <= a;
    data_in <= d;
    bus_strobe <= WR;
    repeat (4) @(posedge sys_clk);
    bus_strobe <= IDLE;
    // released bus must not look like the last value
    data_in <= ~d;
    repeat (5) @(posedge sys_clk);
  endtask : wr

  // read is ce plus oe; answer taken at the edge before release
  task automatic rd(input logic [12:0] a, input int n,
                    output logic [15:0] d, output logic oe_n);
    @(posedge sys_clk);
    addr <= a;
    bus_strobe <= RD;
    repeat (n) @(posedge sys_clk);
    d = data_out;
    oe_n = data_oe_n;
    bus_strobe <= IDLE;
    repeat (5) @(posedge sys_clk);
  endtask : rd
endmodule : fdm_host_bfm

`default_nettype wire

// ### dv/fdm_mode_ctrl_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "fdm_defs.svh"

module flash_disk_operating_mode_ctrl_tb_top;
  import fdm_pkg::*;

  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic hard_reset_in_n = 1'b1;
  logic sleep_wake_pin = 1'b0;
  logic soft_boot_trigger = 1'b0;
  logic mux_interface = 1'b0;
  fdm_strobe_s bus_strobe;
  logic [12:0] addr;
  logic [12:0] boot_addr;
  logic [12:0] sa;
  logic [15:0] data_in;
  logic [15:0] boot_rdata;
  logic [15:0] data_out;
  logic [15:0] rd_d;
  logic [15:0] sv;
  logic data_oe_n;
  logic busy_n;
  logic rd_oe;
  fdm_mode_e mode;
  fdm_inbuf_s inbuf;
  int n_fail = 0;
  int cmp_count = 0;
  int cyc = 0;

  always #4 sys_clk = ~sys_clk;

  fdm_mode_ctrl dut_u (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .bus_strobe(bus_strobe),
    .addr(addr),
    .data_in(data_in),
    .hard_reset_in_n(hard_reset_in_n),
    .sleep_wake_pin(sleep_wake_pin),
    .soft_boot_trigger(soft_boot_trigger),
    .mux_interface(mux_interface),
    .boot_rdata(boot_rdata),
    .boot_addr(boot_addr),
    .data_out(data_out),
    .data_oe_n(data_oe_n),
    .busy_n(busy_n),
    .mode(mode),
    .inbuf(inbuf)
  );

  fdm_host_bfm host_u (
    .sys_clk(sys_clk),
    .bus_strobe(bus_strobe),
    .addr(addr),
    .data_in(data_in),
    .boot_addr(boot_addr),
    .boot_rdata(boot_rdata),
    .data_out(data_out),
    .data_oe_n(data_oe_n)
  );

  function automatic logic [15:0] conf_of(input logic [1:0] t);
    return {14'h0, ~t};
  endfunction : conf_of

  function automatic logic [15:0] boot_word(input logic [12:0] a);
    return {3'h5, a};
  endfunction : boot_word

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic test_done;
    $display("compares=%0d mismatches=%0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : test_done

  // mode moves a few edges after its cause because pins are synchronised
  task automatic chk_mode(input logic [1:0] m);
    repeat (6) @(posedge sys_clk);
    chk({14'h0, mode}, {14'h0, m});
  endtask : chk_mode

  // host side of the control then confirmation sequence
  task automatic set_mode(input logic [1:0] t);
    host_u.wr(`FDM_OFS_MODE_CTRL, {14'h0, t});
    host_u.wr(`FDM_OFS_MODE_CONF, conf_of(t));
  endtask : set_mode

  always @(posedge sys_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      n_fail++;
      test_done();
    end
  end

  initial
  begin
    rd_d = 16'($urandom(32'h084f));
    repeat (10) @(posedge sys_clk);
    rst_n <= 1'b1;
    chk_mode(`FDM_MODE_RESET);
    host_u.wr(`FDM_OFS_SCRATCH, 16'hbeef);
    set_mode(`FDM_MODE_NORMAL);
    chk_mode(`FDM_MODE_NORMAL);
    host_u.rd(`FDM_OFS_SCRATCH, 6, rd_d, rd_oe);
    chk(rd_d, `FDM_RST_SCRATCH);
    for (int i = 0; i < 4; i++)
    begin
      sv = 16'($urandom());
      host_u.wr(`FDM_OFS_SCRATCH, sv);
      host_u.rd(`FDM_OFS_SCRATCH, 6, rd_d, rd_oe);
      chk(rd_d, sv);
      chk({15'h0, rd_oe}, 16'h0);
    end
    host_u.rd(`FDM_OFS_MODE_CTRL, 6, rd_d, rd_oe);
    chk({14'h0, rd_d[1:0]}, {14'h0, `FDM_MODE_NORMAL});
    // wrong complement, then a stray write between the pair
    host_u.wr(`FDM_OFS_MODE_CTRL, 16'h0000);
    host_u.wr(`FDM_OFS_MODE_CONF, 16'h0000);
    chk_mode(`FDM_MODE_NORMAL);
    host_u.wr(`FDM_OFS_MODE_CTRL, 16'h0000);
    host_u.wr(`FDM_OFS_SLEEP_PIN_CTRL, 16'h0000);
    host_u.wr(`FDM_OFS_MODE_CONF, conf_of(`FDM_MODE_RESET));
    chk_mode(`FDM_MODE_NORMAL);
    set_mode(`FDM_MODE_RESET);
    chk_mode(`FDM_MODE_RESET);
    host_u.rd(`FDM_OFS_SCRATCH, 6, rd_d, rd_oe);
    chk(rd_d, 16'h0000);
    host_u.wr(`FDM_OFS_SCRATCH, ~sv);
    set_mode(`FDM_MODE_NORMAL);
    host_u.rd(`FDM_OFS_SCRATCH, 6, rd_d, rd_oe);
    chk(rd_d, sv);
    set_mode(`FDM_MODE_SLEEP);
    chk_mode(`FDM_MODE_SLEEP);
    chk({12'h0, inbuf.addr, inbuf.data, inbuf.we, inbuf.oe}, 16'h0);
    host_u.wr(`FDM_OFS_SCRATCH, ~sv);
    host_u.rd(`FDM_OFS_SCRATCH, 6, rd_d, rd_oe);
    chk({15'h0, rd_oe}, 16'h1);
    for (int i = 0; i < 4; i++)
      host_u.rd(`FDM_WAKE_ADDR, 6, rd_d, rd_oe);
    chk_mode(`FDM_MODE_NORMAL);
    host_u.rd(`FDM_OFS_SCRATCH, 6, rd_d, rd_oe);
    chk(rd_d, sv);
    // one long boot read wakes and returns good data
    set_mode(`FDM_MODE_SLEEP);
    chk_mode(`FDM_MODE_SLEEP);
    sa = 13'($urandom_range(0, 32'hfff));
    host_u.rd(sa, 40, rd_d, rd_oe);
    chk(rd_d, boot_word(sa));
    chk({15'h0, rd_oe}, 16'h0);
    chk_mode(`FDM_MODE_NORMAL);
    // rising edge first, so the pin is high before the falling case
    for (int e = 1; e >= 0; e--)
    begin
      host_u.wr(`FDM_OFS_SLEEP_PIN_CTRL, {14'h0, e[0], 1'b1});
      set_mode(`FDM_MODE_SLEEP);
      chk_mode(`FDM_MODE_SLEEP);
      sleep_wake_pin <= e[0];
      chk_mode(`FDM_MODE_NORMAL);
    end
    // multiplexed bus: a long boot read must not wake
    set_mode(`FDM_MODE_SLEEP);
    mux_interface <= 1'b1;
    chk_mode(`FDM_MODE_SLEEP);
    chk({11'h0, inbuf}, 16'h0);
    host_u.rd(sa, 40, rd_d, rd_oe);
    chk({15'h0, rd_oe}, 16'h1);
    chk_mode(`FDM_MODE_SLEEP);
    mux_interface <= 1'b0;
    for (int i = 0; i < 4; i++)
      host_u.rd(`FDM_WAKE_ADDR, 6, rd_d, rd_oe);
    chk_mode(`FDM_MODE_NORMAL);
    hard_reset_in_n <= 1'b0;
    chk_mode(`FDM_MODE_SLEEP);
    chk({15'h0, busy_n}, 16'h0);
    hard_reset_in_n <= 1'b1;
    chk_mode(`FDM_MODE_RESET);
    chk({15'h0, busy_n}, 16'h1);
    // a hard reset between control and confirmation cancels the pair
    host_u.wr(`FDM_OFS_MODE_CTRL, {14'h0, `FDM_MODE_NORMAL});
    hard_reset_in_n <= 1'b0;
    chk_mode(`FDM_MODE_RESET);
    chk({15'h0, busy_n}, 16'h0);
    hard_reset_in_n <= 1'b1;
    host_u.wr(`FDM_OFS_MODE_CONF, conf_of(`FDM_MODE_NORMAL));
    chk_mode(`FDM_MODE_RESET);
    set_mode(`FDM_MODE_NORMAL);
    soft_boot_trigger <= 1'b1;
    repeat (3) @(posedge sys_clk);
    soft_boot_trigger <= 1'b0;
    chk_mode(`FDM_MODE_RESET);
    test_done();
  end
endmodule : flash_disk_operating_mode_ctrl_tb_top

`default_nettype wire

// ### rtl/fdm_defs.svh
`ifndef FDM_DEFS_SVH
`define FDM_DEFS_SVH

// mode codes, gray along reset -> normal -> sleep
`define FDM_MODE_RESET 2'h0
`define FDM_MODE_NORMAL 2'h1
`define FDM_MODE_SLEEP 2'h3

// register window and offsets
`define FDM_REG_WIN 5'h10
`define FDM_OFS_MODE_CTRL 13'h1002
`define FDM_OFS_MODE_CONF 13'h1003
`define FDM_OFS_SLEEP_PIN_CTRL 13'h1004
`define FDM_OFS_SCRATCH 13'h1005

// boot-window wake address and read count
`define FDM_WAKE_ADDR 13'h1fff
`define FDM_WAKE_READS 3'h4

// sleep pin control fields
`define FDM_PIN_EN_BIT 0
`define FDM_PIN_RISE_BIT 1

// reset values
`define FDM_RST_SLEEP_PIN_CTRL 2'h0
`define FDM_RST_SCRATCH 16'h0000

// timing
`define FDM_CLK_PERIOD_PS 8000
`define FDM_EXT_ACCESS_NS 200
`define FDM_EXT_ACCESS_CYC \
  ((`FDM_EXT_ACCESS_NS * 1000 + `FDM_CLK_PERIOD_PS - 1) / `FDM_CLK_PERIOD_PS)

`endif

// ### rtl/fdm_mode_ctrl.sv
// Behaviour
// - present mode readable in the mode control register outside sleep
// - hard reset input low puts normal or sleep in sleep mode; reset mode stays reset
// - power-up reset leaves the device in reset mode
// - control write then matching confirmation write enters normal mode
// - normal returns to reset by write sequence or soft boot trigger
// - sleep sequence enters sleep only once chip select negated
// - hard reset held in normal gives sleep; release gives reset
// - four boot reads at 1fff wake sleep to normal; data undefined
// - one extended boot read wakes sleep, standard interface only
// - sleep pin edge chosen by sleep pin control wakes the device
// - reset mode drops writes except control and confirmation
// - reset mode register reads return zero
// - sleep ignores writes and leaves data bus undriven
// - sleep entry and exit leave every register unchanged
// - sleep with chip select negated disables the input buffers
// - write is ce plus we, read is ce plus oe
`timescale 1ns/1ps
`default_nettype none
`include "fdm_defs.svh"

module fdm_mode_ctrl (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire fdm_pkg::fdm_strobe_s bus_strobe,
  input wire logic [12:0] addr,
  input wire logic [15:0] data_in,
  input wire logic hard_reset_in_n,
  input wire logic sleep_wake_pin,
  input wire logic soft_boot_trigger,
  input wire logic mux_interface,
  input wire logic [15:0] boot_rdata,
  output logic [12:0] boot_addr,
  output logic [15:0] data_out,
  output logic data_oe_n,
  output logic busy_n,
  output fdm_pkg::fdm_mode_e mode,
  output fdm_pkg::fdm_inbuf_s inbuf
);
  import fdm_pkg::*;

  localparam int EXT_CYC = `FDM_EXT_ACCESS_CYC;

  // bus pins other than ce gated by the buffer enables before they are synchronised
  fdm_strobe_s strobe_g;
  logic [12:0] addr_g;
  logic [15:0] data_g;
  fdm_strobe_s st_s;
  logic [12:0] addr_s;
  logic [15:0] data_s;
  logic hrst_n_s;
  logic pin_s;
  logic soft_s;
  logic mux_s;

  always_comb
  begin
    strobe_g.ce_n = bus_strobe.ce_n;
    strobe_g.we_n = inbuf.we ? bus_strobe.we_n : 1'b1;
    strobe_g.oe_n = inbuf.oe ? bus_strobe.oe_n : 1'b1;
    strobe_g.avd_n = inbuf.avd ? bus_strobe.avd_n : 1'b1;
    addr_g = inbuf.addr ? addr : 13'h0000;
    data_g = inbuf.data ? data_in : 16'h0000;
  end

  fdm_sync #(
    .W(37),
    .RST_VAL({4'hf, 13'h0000, 16'h0000, 4'h0})
  ) u_pin_sync (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .d({strobe_g, addr_g, data_g, hard_reset_in_n, sleep_wake_pin,
        soft_boot_trigger, mux_interface}),
    .q({st_s, addr_s, data_s, hrst_n_s, pin_s, soft_s, mux_s})
  );

  // bus cycle decode
  logic wr_now;
  logic rd_now;
  logic wr_prev;
  logic rd_prev;
  logic wr_end;
  logic rd_start;
  logic [12:0] ad_latch;
  logic [12:0] eff_addr;
  logic in_reg;

  assign wr_now = !st_s.ce_n && !st_s.we_n;
  assign rd_now = !st_s.ce_n && !st_s.oe_n;
  assign wr_end = wr_prev && !wr_now;
  assign rd_start = rd_now && !rd_prev;
  assign eff_addr = mux_s ? ad_latch : addr_s;
  assign in_reg = eff_addr[12:8] == `FDM_REG_WIN;

  // state
  logic [12:0] wr_addr;
  logic [15:0] wr_data;
  logic [1:0] pend_mode;
  logic pend_valid;
  logic sleep_armed;
  logic hold;
  logic [2:0] wake_cnt;
  logic [5:0] ext_cnt;
  logic [1:0] sleep_pin_ctrl;
  logic [15:0] scratch;
  logic pin_prev;
  logic soft_prev;

  logic next_wr_prev;
  logic next_rd_prev;
  logic [12:0] next_ad_latch;
  logic [12:0] next_wr_addr;
  logic [15:0] next_wr_data;
  fdm_mode_e next_mode;
  logic [1:0] next_pend_mode;
  logic next_pend_valid;
  logic next_sleep_armed;
  logic next_hold;
  logic [2:0] next_wake_cnt;
  logic [5:0] next_ext_cnt;
  logic [1:0] next_sleep_pin_ctrl;
  logic [15:0] next_scratch;
  logic next_pin_prev;
  logic next_soft_prev;
  logic pin_edge;

  always_comb
  begin
    next_wr_prev = wr_now;
    next_rd_prev = rd_now;
    next_ad_latch = st_s.avd_n ? ad_latch : data_s[12:0];
    next_wr_addr = wr_now ? eff_addr : wr_addr;
    next_wr_data = wr_now ? data_s : wr_data;
    next_mode = mode;
    next_pend_mode = pend_mode;
    next_pend_valid = pend_valid;
    next_sleep_armed = sleep_armed;
    next_hold = hold;
    next_wake_cnt = wake_cnt;
    next_ext_cnt = 6'h00;
    next_sleep_pin_ctrl = sleep_pin_ctrl;
    next_scratch = scratch;
    next_pin_prev = pin_s;
    next_soft_prev = soft_s;
    pin_edge = sleep_pin_ctrl[`FDM_PIN_RISE_BIT] ? (pin_s && !pin_prev)
                                                 : (!pin_s && pin_prev);

    // writes are taken at the end of the cycle, when data is settled
    if (wr_end && mode != FDM_SLEEP)
    begin
      next_pend_valid = 1'b0;
      unique case (wr_addr)
        `FDM_OFS_MODE_CTRL:
        begin
          next_pend_mode = wr_data[1:0];
          next_pend_valid = 1'b1;
        end
        `FDM_OFS_MODE_CONF:
        begin
          if (pend_valid && wr_data[1:0] == ~pend_mode)
          begin
            if (mode == FDM_RESET && pend_mode == `FDM_MODE_NORMAL)
              next_mode = FDM_NORMAL;
            else if (mode == FDM_NORMAL && pend_mode == `FDM_MODE_RESET)
              next_mode = FDM_RESET;
            else if (mode == FDM_NORMAL && pend_mode == `FDM_MODE_SLEEP)
              next_sleep_armed = 1'b1;
          end
        end
        `FDM_OFS_SLEEP_PIN_CTRL:
        begin
          if (mode == FDM_NORMAL)
            next_sleep_pin_ctrl = wr_data[1:0];
        end
        `FDM_OFS_SCRATCH:
        begin
          if (mode == FDM_NORMAL)
            next_scratch = wr_data;
        end
        default:
        begin
        end
      endcase
    end

    // sleep waits for the host to let go of chip select
    if (mode == FDM_NORMAL && sleep_armed && st_s.ce_n)
    begin
      next_mode = FDM_SLEEP;
      next_sleep_armed = 1'b0;
      next_wake_cnt = 3'h0;
    end

    if (mode == FDM_NORMAL && soft_s && !soft_prev)
    begin
      next_mode = FDM_RESET;
      next_sleep_armed = 1'b0;
    end

    if (mode == FDM_SLEEP)
    begin
      if (rd_start)
      begin
        if (eff_addr == `FDM_WAKE_ADDR)
        begin
          if (wake_cnt == `FDM_WAKE_READS - 3'h1)
          begin
            next_mode = FDM_NORMAL;
            next_wake_cnt = 3'h0;
          end
          else
            next_wake_cnt = wake_cnt + 3'h1;
        end
        else
          next_wake_cnt = 3'h0;
      end
      // a long boot-window read wakes us while the host still waits
      if (rd_now && !in_reg && !mux_s)
      begin
        next_ext_cnt = ext_cnt + 6'h01;
        if (ext_cnt == 6'(EXT_CYC - 1))
        begin
          next_mode = FDM_NORMAL;
          next_wake_cnt = 3'h0;
        end
      end
      if (sleep_pin_ctrl[`FDM_PIN_EN_BIT] && pin_edge)
      begin
        next_mode = FDM_NORMAL;
        next_wake_cnt = 3'h0;
      end
    end

    // hard reset outranks every mode and sequence decision above; register writes still land
    if (!hrst_n_s)
    begin
      next_pend_valid = 1'b0;
      next_sleep_armed = 1'b0;
      if (mode == FDM_NORMAL || mode == FDM_SLEEP)
      begin
        next_mode = FDM_SLEEP;
        next_hold = 1'b1;
      end
      else
        next_mode = FDM_RESET;
    end
    else if (hold)
    begin
      next_mode = FDM_RESET;
      next_hold = 1'b0;
    end
  end

  // registers keep their values across sleep; only power-up clears them
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wr_prev <= 1'b0;
      rd_prev <= 1'b0;
      ad_latch <= 13'h0000;
      wr_addr <= 13'h0000;
      wr_data <= 16'h0000;
      mode <= FDM_RESET;
      pend_mode <= 2'h0;
      pend_valid <= 1'b0;
      sleep_armed <= 1'b0;
      hold <= 1'b0;
      wake_cnt <= 3'h0;
      ext_cnt <= 6'h00;
      sleep_pin_ctrl <= `FDM_RST_SLEEP_PIN_CTRL;
      scratch <= `FDM_RST_SCRATCH;
      pin_prev <= 1'b0;
      soft_prev <= 1'b0;
    end
    else
    begin
      wr_prev <= next_wr_prev;
      rd_prev <= next_rd_prev;
      ad_latch <= next_ad_latch;
      wr_addr <= next_wr_addr;
      wr_data <= next_wr_data;
      mode <= next_mode;
      pend_mode <= next_pend_mode;
      pend_valid <= next_pend_valid;
      sleep_armed <= next_sleep_armed;
      hold <= next_hold;
      wake_cnt <= next_wake_cnt;
      ext_cnt <= next_ext_cnt;
      sleep_pin_ctrl <= next_sleep_pin_ctrl;
      scratch <= next_scratch;
      pin_prev <= next_pin_prev;
      soft_prev <= next_soft_prev;
    end
  end

  // read path and pin-facing outputs
  logic [15:0] reg_rdata;
  logic [15:0] next_data_out;
  logic next_data_oe_n;
  logic next_busy_n;
  fdm_inbuf_s next_inbuf;
  logic bufs_on;

  always_comb
  begin
    unique case (eff_addr)
      `FDM_OFS_MODE_CTRL: reg_rdata = {14'h0000, mode};
      `FDM_OFS_SLEEP_PIN_CTRL: reg_rdata = {14'h0000, sleep_pin_ctrl};
      `FDM_OFS_SCRATCH: reg_rdata = scratch;
      default: reg_rdata = 16'h0000;
    endcase
    next_data_out = data_out;
    next_data_oe_n = 1'b1;
    if (rd_now && mode != FDM_SLEEP)
    begin
      next_data_oe_n = 1'b0;
      if (in_reg)
        next_data_out = (mode == FDM_RESET) ? 16'h0000 : reg_rdata;
      else
        next_data_out = boot_rdata;
    end
    // held busy through a hard reset pulse so the host can wait on it
    next_busy_n = hrst_n_s && !hold;
    bufs_on = !(mode == FDM_SLEEP && st_s.ce_n);
    next_inbuf.addr = bufs_on && !mux_s;
    next_inbuf.data = bufs_on;
    next_inbuf.we = bufs_on;
    next_inbuf.oe = bufs_on;
    next_inbuf.avd = bufs_on && mux_s;
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      data_out <= 16'h0000;
      data_oe_n <= 1'b1;
      busy_n <= 1'b0;
      boot_addr <= 13'h0000;
      inbuf <= '1;
    end
    else
    begin
      data_out <= next_data_out;
      data_oe_n <= next_data_oe_n;
      busy_n <= next_busy_n;
      boot_addr <= eff_addr;
      inbuf <= next_inbuf;
    end
  end

  a_mode_code_legal: assert property (@(posedge sys_clk) disable iff (!rst_n)
    mode != 2'h2)
    else $error("illegal mode code");

  a_confirm_gates_normal: assert property (@(posedge sys_clk)
    disable iff (!rst_n)
    mode == FDM_RESET && !(wr_end && wr_addr == `FDM_OFS_MODE_CONF
      && pend_valid) |=> mode == FDM_RESET)
    else $error("left reset mode without confirmation");

  a_sleep_needs_cs: assert property (@(posedge sys_clk) disable iff (!rst_n)
    mode == FDM_NORMAL && !st_s.ce_n && hrst_n_s |=> mode != FDM_SLEEP)
    else $error("sleep entered with chip select asserted");

  a_hard_hold_seq: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !hrst_n_s && mode != FDM_RESET ##1 hrst_n_s |=> mode == FDM_RESET)
    else $error("hard reset release did not give reset mode");

  a_four_reads_wake: assert property (@(posedge sys_clk) disable iff (!rst_n)
    mode == FDM_SLEEP && hrst_n_s && rd_start
      && eff_addr == `FDM_WAKE_ADDR && wake_cnt == 3'h3
      |=> mode == FDM_NORMAL)
    else $error("fourth wake read did not wake");

  a_reset_drop_write: assert property (@(posedge sys_clk) disable iff (!rst_n)
    wr_end && mode == FDM_RESET && wr_addr == `FDM_OFS_SCRATCH
      |=> $stable(scratch))
    else $error("write taken in reset mode");

  a_reset_reads_zero: assert property (@(posedge sys_clk) disable iff (!rst_n)
    rd_now && mode == FDM_RESET && in_reg
      |=> !data_oe_n && data_out == 16'h0000)
    else $error("reset mode read not zero");

  a_sleep_no_drive: assert property (@(posedge sys_clk) disable iff (!rst_n)
    mode == FDM_SLEEP |=> data_oe_n)
    else $error("data bus driven in sleep");

  a_sleep_keeps_regs: assert property (@(posedge sys_clk) disable iff (!rst_n)
    mode == FDM_SLEEP |=> $stable(scratch) && $stable(sleep_pin_ctrl))
    else $error("register changed in sleep");

  a_sleep_bufs_off: assert property (@(posedge sys_clk) disable iff (!rst_n)
    mode == FDM_SLEEP && st_s.ce_n
      |=> inbuf == 5'h00)
    else $error("input buffers on in sleep");

endmodule : fdm_mode_ctrl

`default_nettype wire

// ### rtl/fdm_pkg.sv
`include "fdm_defs.svh"

package fdm_pkg;

  typedef enum logic [1:0]
  {
    FDM_RESET = `FDM_MODE_RESET,
    FDM_NORMAL = `FDM_MODE_NORMAL,
    FDM_SLEEP = `FDM_MODE_SLEEP
  } fdm_mode_e;

  // active-high enables of the input buffers
  typedef struct packed
  {
    logic addr;
    logic data;
    logic we;
    logic oe;
    logic avd;
  } fdm_inbuf_s;

  // host bus strobes, all active low
  typedef struct packed
  {
    logic ce_n;
    logic we_n;
    logic oe_n;
    logic avd_n;
  } fdm_strobe_s;

endpackage : fdm_pkg

// ### rtl/fdm_sync.sv
`timescale 1ns/1ps
`default_nettype none

module fdm_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] meta;

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta <= RST_VAL;
      q <= RST_VAL;
    end
    else
    begin
      meta <= d;
      q <= meta;
    end
  end

endmodule : fdm_sync

`default_nettype wire
